// ==== core/serial_timer_pin_mux.sv ====
// serial_timer_pin_mux: port E serial pins and three timer pins with
// their control registers, reached over APB.
// assumes pins synchronous to pclk; the serial engine sits outside.
//
// Function
// [RL1] receive and transmit run at once
// [RL2] port E pins reset to gpio inputs
// [RL3] gpio direction follows port E direction
// [RL4] control bit hands pin to serial function
// [RL5] receive pin is input to shifter
// [RL6] transmit pin drives serial transmit data
// [RL7] serial clock pin is input or output
// [RL8] stop keeps role, inputs ignored
// [RL9] stop: driver off, keeper holds level
// [RL10] wait state leaves pins unchanged
// [RL11] three identical independent timers with pins
// [RL12] timer counts internal or external events
// [RL13] timer interrupts or signals on count
// [RL14] event and measure modes use input
// [RL15] watchdog, timer, pwm modes drive output
// [RL16] timer pins reset to gpio inputs
// [RL17] timer register selects gpio or timer
// [RL18] peripheral function overrides gpio direction
//
// Register access over APB and the address map are this design's own decisions.
`timescale 1ns/100ps
module serial_timer_pin_mux #(
  parameter int TW = 24,
  parameter int NTMR = 3
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [pin_mux_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic stop_mode,
  input wire logic [2:0] port_e_pin_i,
  output pin_mux_pkg::pin_grp_t port_e_pins,
  input wire logic [2:0] timer_pin_i,
  output pin_mux_pkg::pin_grp_t timer_pins,
  input wire pin_mux_pkg::ser_drv_t ser_drv,
  output pin_mux_pkg::ser_in_t ser_in,
  output logic irq
);

  logic [2:0] pe_ctrl_q;
  logic [2:0] pe_dir_q;
  logic [2:0] pe_out_q;
  logic [2:0] pe_in;
  logic [pin_mux_pkg::TCS_W-1:0] tcs_q [NTMR];
  logic [TW-1:0] tlim_q [NTMR];
  logic [TW-1:0] tcnt [NTMR];
  logic [NTMR-1:0] tick;
  logic [NTMR-1:0] tout;
  logic [NTMR-1:0] tio_in;
  logic [NTMR-1:0] stat_q;
  logic [NTMR-1:0] mask_q;
  logic [31:0] rd_d;
  logic err_d;
  logic capture;
  logic armed_q;
  logic wr_en;
  logic [2:0] pe_fo;
  logic [2:0] pe_foe;
  pin_mux_pkg::tmr_mode_t tmode [NTMR];

  // ----------------------------------------------------------------
  // apb handshake
  // ----------------------------------------------------------------
  // held-off access phase while the clock enable is low
  // a setup lost to a low enable is taken up in the access phase
  assign capture = psel && clk_en && !armed_q;
  assign pready = clk_en && armed_q;
  assign wr_en = psel && penable && pwrite && pready;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      armed_q <= 1'b0;
    end else if (clk_en) begin
      armed_q <= capture;
    end
  end

  always_comb begin
    rd_d = '0;
    err_d = 1'b1;
    if (paddr == pin_mux_pkg::PE_CTRL_OFF) begin
      rd_d[2:0] = pe_ctrl_q;
      err_d = 1'b0;
    end
    if (paddr == pin_mux_pkg::PE_DIR_OFF) begin
      rd_d[2:0] = pe_dir_q;
      err_d = 1'b0;
    end
    if (paddr == pin_mux_pkg::PE_DATA_OFF) begin
      rd_d[2:0] = pe_in;
      err_d = 1'b0;
    end
    if (paddr == pin_mux_pkg::IRQ_STAT_OFF) begin
      rd_d[NTMR-1:0] = stat_q;
      err_d = 1'b0;
    end
    if (paddr == pin_mux_pkg::IRQ_MASK_OFF) begin
      rd_d[NTMR-1:0] = mask_q;
      err_d = 1'b0;
    end
    for (int i = 0; i < NTMR; i++) begin
      if (paddr == pin_mux_pkg::TCS_BASE_OFF
          + pin_mux_pkg::REG_STEP * 8'(i)) begin
        rd_d[pin_mux_pkg::TCS_W-1:0] = tcs_q[i];
        rd_d[pin_mux_pkg::TCS_PIN_BIT] = tio_in[i];
        err_d = 1'b0;
      end
      if (paddr == pin_mux_pkg::TLIM_BASE_OFF
          + pin_mux_pkg::REG_STEP * 8'(i)) begin
        rd_d[TW-1:0] = tlim_q[i];
        err_d = 1'b0;
      end
      if (paddr == pin_mux_pkg::TCNT_BASE_OFF
          + pin_mux_pkg::REG_STEP * 8'(i)) begin
        rd_d[TW-1:0] = tcnt[i];
        err_d = 1'b0;
      end
    end
  end

  // read data and error captured once per transfer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
      pslverr <= 1'b0;
    end else if (capture) begin
      prdata <= pwrite ? '0 : rd_d;
      pslverr <= err_d;
    end
  end

  // ----------------------------------------------------------------
  // port e registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pe_ctrl_q <= pin_mux_pkg::PE_CTRL_RST; // RL2
      pe_dir_q <= pin_mux_pkg::PE_DIR_RST; // RL2
      pe_out_q <= pin_mux_pkg::PE_OUT_RST;
    end else if (wr_en) begin
      if (paddr == pin_mux_pkg::PE_CTRL_OFF) pe_ctrl_q <= pwdata[2:0];
      if (paddr == pin_mux_pkg::PE_DIR_OFF) pe_dir_q <= pwdata[2:0];
      if (paddr == pin_mux_pkg::PE_DATA_OFF) pe_out_q <= pwdata[2:0];
    end
  end

  // ----------------------------------------------------------------
  // timer registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NTMR; i++) begin
        tcs_q[i] <= pin_mux_pkg::TCS_RST; // RL16
        tlim_q[i] <= pin_mux_pkg::TLIM_RST[TW-1:0];
      end
    end else if (wr_en) begin
      for (int i = 0; i < NTMR; i++) begin
        if (paddr == pin_mux_pkg::TCS_BASE_OFF
            + pin_mux_pkg::REG_STEP * 8'(i))
          tcs_q[i] <= pwdata[pin_mux_pkg::TCS_W-1:0]; // RL17
        if (paddr == pin_mux_pkg::TLIM_BASE_OFF
            + pin_mux_pkg::REG_STEP * 8'(i))
          tlim_q[i] <= pwdata[TW-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // interrupt status and mask
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_q <= '0;
      mask_q <= pin_mux_pkg::IRQ_MASK_RST;
    end else if (clk_en) begin
      // a new tick beats a write-one-to-clear in the same cycle
      if (wr_en && paddr == pin_mux_pkg::IRQ_STAT_OFF)
        stat_q <= tick | (stat_q & ~pwdata[NTMR-1:0]); // RL13
      else
        stat_q <= stat_q | tick; // RL13
      if (wr_en && paddr == pin_mux_pkg::IRQ_MASK_OFF)
        mask_q <= pwdata[NTMR-1:0];
    end
  end

  assign irq = |(stat_q & mask_q); // RL13

  // ----------------------------------------------------------------
  // port e pins and serial routing
  // ----------------------------------------------------------------
  // receive never drives, transmit always drives, clock as engine says
  assign pe_fo = {ser_drv.sclk_o, ser_drv.txd, 1'b0}; // RL6
  assign pe_foe = {ser_drv.sclk_oe, 1'b1, 1'b0}; // RL5 RL7
  // receive and transmit paths are separate, so both run together
  assign ser_in.rxd = pe_ctrl_q[0] ? pe_in[0] : 1'b1; // RL1 RL5
  assign ser_in.sclk_i = pe_ctrl_q[2] ? pe_in[2] : 1'b0; // RL7

  // only stop gates the pins; a wait state has no path in here
  generate
    for (genvar g = 0; g < 3; g++) begin : g_pe
      pin_cell u_cell (
        .pclk(pclk),
        .presetn(presetn),
        .clk_en(clk_en),
        .stop_mode(stop_mode), // RL10
        .func_sel(pe_ctrl_q[g]), // RL4
        .func_o(pe_fo[g]),
        .func_oe(pe_foe[g]),
        .gpio_o(pe_out_q[g]),
        .gpio_oe(pe_dir_q[g]), // RL3
        .pin_i(port_e_pin_i[g]),
        .pin_o(port_e_pins.o[g]),
        .pin_oe(port_e_pins.oe[g]),
        .pin_keep(port_e_pins.keep[g]),
        .in_q(pe_in[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // timers and their pins
  // ----------------------------------------------------------------
  generate
    for (genvar g = 0; g < NTMR; g++) begin : g_tmr
      logic tsel;
      logic toe;
      logic tin;
      assign tmode[g] = pin_mux_pkg::tmr_mode_t'(
        tcs_q[g][pin_mux_pkg::TCS_MODE_LSB +: pin_mux_pkg::TCS_MODE_W]);
      assign tsel = tmode[g] != pin_mux_pkg::TM_GPIO; // RL17
      assign toe = tmode[g] == pin_mux_pkg::TM_WATCHDOG
                || tmode[g] == pin_mux_pkg::TM_TIMER
                || tmode[g] == pin_mux_pkg::TM_PWM; // RL14 RL15
      assign tin = (tmode[g] == pin_mux_pkg::TM_EVENT
                || tmode[g] == pin_mux_pkg::TM_MEASURE) && tio_in[g];

      timer_unit #(.TW(TW)) u_tmr ( // RL11
        .pclk(pclk),
        .presetn(presetn),
        .clk_en(clk_en),
        .mode(tmode[g]),
        .enable(tcs_q[g][pin_mux_pkg::TCS_EN_BIT]),
        .limit(tlim_q[g]),
        .pin_in(tin), // RL12
        .count_q(tcnt[g]),
        .tick_q(tick[g]),
        .tout_q(tout[g])
      );

      pin_cell u_cell (
        .pclk(pclk),
        .presetn(presetn),
        .clk_en(clk_en),
        .stop_mode(stop_mode), // RL10
        .func_sel(tsel),
        .func_o(tout[g]),
        .func_oe(toe), // RL18
        .gpio_o(tcs_q[g][pin_mux_pkg::TCS_OUT_BIT]),
        .gpio_oe(tcs_q[g][pin_mux_pkg::TCS_DIR_BIT]),
        .pin_i(timer_pin_i[g]),
        .pin_o(timer_pins.o[g]),
        .pin_oe(timer_pins.oe[g]),
        .pin_keep(timer_pins.keep[g]),
        .in_q(tio_in[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_full_duplex: assert property (@(posedge pclk) // RL1
    disable iff (!presetn)
    clk_en && !stop_mode && pe_ctrl_q[1:0] == 2'h3
    |=> port_e_pins.oe[1] && !port_e_pins.oe[0])
    else $error("rx and tx not both active");

  chk_pe_reset_in: assert property (@(posedge pclk) // RL2
    disable iff (!presetn)
    $past(!presetn) |-> pe_ctrl_q == 3'h0 && port_e_pins.oe == 3'h0)
    else $error("port e pin not input after reset");

  chk_gpio_dir: assert property (@(posedge pclk) // RL3
    disable iff (!presetn)
    clk_en && !stop_mode && !pe_ctrl_q[2]
    |=> port_e_pins.oe[2] == $past(pe_dir_q[2]))
    else $error("gpio direction not followed");

  chk_rx_input: assert property (@(posedge pclk) // RL5
    disable iff (!presetn)
    clk_en && !stop_mode && pe_ctrl_q[0] |=> !port_e_pins.oe[0])
    else $error("receive pin driven");

  chk_rx_route: assert property (@(posedge pclk) // RL5
    disable iff (!presetn)
    clk_en && !stop_mode && pe_ctrl_q[0] ##1 pe_ctrl_q[0]
    |-> ser_in.rxd == $past(port_e_pin_i[0]))
    else $error("receive data not routed");

  chk_tx_drive: assert property (@(posedge pclk) // RL6
    disable iff (!presetn)
    clk_en && !stop_mode && pe_ctrl_q[1]
    |=> port_e_pins.oe[1] && port_e_pins.o[1] == $past(ser_drv.txd))
    else $error("transmit pin not driven");

  chk_sclk_dir: assert property (@(posedge pclk) // RL4 RL7
    disable iff (!presetn)
    clk_en && !stop_mode && pe_ctrl_q[2]
    |=> port_e_pins.oe[2] == $past(ser_drv.sclk_oe)
        && port_e_pins.o[2] == $past(ser_drv.sclk_o))
    else $error("serial clock pin wrong");

  chk_tmr_input: assert property (@(posedge pclk) // RL14
    disable iff (!presetn)
    clk_en && !stop_mode && (tmode[0] == pin_mux_pkg::TM_EVENT
    || tmode[0] == pin_mux_pkg::TM_MEASURE) |=> !timer_pins.oe[0])
    else $error("timer input pin driven");

  chk_tmr_output: assert property (@(posedge pclk) // RL15
    disable iff (!presetn)
    clk_en && !stop_mode && (tmode[1] == pin_mux_pkg::TM_WATCHDOG
    || tmode[1] == pin_mux_pkg::TM_TIMER
    || tmode[1] == pin_mux_pkg::TM_PWM) |=> timer_pins.oe[1])
    else $error("timer output pin not driven");

  chk_tmr_reset_in: assert property (@(posedge pclk) // RL16
    disable iff (!presetn)
    $past(!presetn) |-> timer_pins.oe == 3'h0 && tmode[2] == 3'h0)
    else $error("timer pin not input after reset");

  chk_tmr_gpio: assert property (@(posedge pclk) // RL17
    disable iff (!presetn)
    clk_en && !stop_mode && tmode[2] == pin_mux_pkg::TM_GPIO
    |=> timer_pins.oe[2] == $past(tcs_q[2][pin_mux_pkg::TCS_DIR_BIT])
        && timer_pins.o[2] == $past(tcs_q[2][pin_mux_pkg::TCS_OUT_BIT]))
    else $error("timer gpio setting not applied");

  chk_stop_off: assert property (@(posedge pclk) // RL8 RL9
    disable iff (!presetn)
    clk_en && stop_mode |=> port_e_pins.oe == 3'h0 && timer_pins.oe == 3'h0)
    else $error("driver active in stop");

  chk_irq_tick: assert property (@(posedge pclk) // RL13
    disable iff (!presetn)
    clk_en && tick[0] && mask_q[0] |=> irq && stat_q[0])
    else $error("timer event lost");

  chk_peri_dir: assert property (@(posedge pclk) // RL18
    disable iff (!presetn)
    clk_en && !stop_mode && pe_ctrl_q[1] && !pe_dir_q[1]
    |=> port_e_pins.oe[1])
    else $error("gpio direction overrode peripheral");

endmodule : serial_timer_pin_mux

// ==== core/pin_mux_pkg.sv ====
// pin_mux_pkg: register map, field layout, reset values and carriers
// for the serial and timer pin multiplexer.
// assumes a 32-bit APB register bus with byte addresses.
package pin_mux_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] PE_CTRL_OFF = 8'h00;
  localparam logic [7:0] PE_DIR_OFF = 8'h04;
  localparam logic [7:0] PE_DATA_OFF = 8'h08;
  localparam logic [7:0] TCS_BASE_OFF = 8'h0C;
  localparam logic [7:0] TLIM_BASE_OFF = 8'h18;
  localparam logic [7:0] TCNT_BASE_OFF = 8'h24;
  localparam logic [7:0] IRQ_STAT_OFF = 8'h30;
  localparam logic [7:0] IRQ_MASK_OFF = 8'h34;
  localparam logic [7:0] REG_STEP = 8'h04;

  // ----------------------------------------------------------------
  // timer control/status fields
  // ----------------------------------------------------------------
  localparam int TCS_MODE_LSB = 0;
  localparam int TCS_MODE_W = 3;
  localparam int TCS_DIR_BIT = 3;
  localparam int TCS_OUT_BIT = 4;
  localparam int TCS_EN_BIT = 5;
  localparam int TCS_PIN_BIT = 6;
  localparam int TCS_W = 6;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [2:0] PE_CTRL_RST = 3'h0;
  localparam logic [2:0] PE_DIR_RST = 3'h0;
  localparam logic [2:0] PE_OUT_RST = 3'h0;
  localparam logic [5:0] TCS_RST = 6'h00;
  localparam logic [31:0] TLIM_RST = 32'h0000_FFFF;
  localparam logic [2:0] IRQ_MASK_RST = 3'h0;

  typedef enum logic [2:0] {
    TM_GPIO, TM_EVENT, TM_MEASURE, TM_WATCHDOG, TM_TIMER, TM_PWM
  } tmr_mode_t;

  typedef struct packed {
    logic [2:0] o;
    logic [2:0] oe;
    logic [2:0] keep;
  } pin_grp_t;

  typedef struct packed {
    logic txd;
    logic sclk_o;
    logic sclk_oe;
  } ser_drv_t;

  typedef struct packed {
    logic rxd;
    logic sclk_i;
  } ser_in_t;

endpackage : pin_mux_pkg

// ==== core/pin_cell.sv ====
// pin_cell: one multiplexed pin with peripheral/gpio select and
// stop-state retention with keeper.
// assumes inputs synchronous to pclk.
`timescale 1ns/100ps
module pin_cell (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic stop_mode,
  input wire logic func_sel,
  input wire logic func_o,
  input wire logic func_oe,
  input wire logic gpio_o,
  input wire logic gpio_oe,
  input wire logic pin_i,
  output logic pin_o,
  output logic pin_oe,
  output logic pin_keep,
  output logic in_q
);

  // ----------------------------------------------------------------
  // drive and sample
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_o <= 1'b0;
      pin_oe <= 1'b0;
      pin_keep <= 1'b0;
      in_q <= 1'b0;
    end else if (clk_en) begin
      if (stop_mode) begin
        // last level held, driver released, keeper holds it if the pin was driven
        pin_oe <= 1'b0; // RL9
        pin_keep <= pin_keep | pin_oe; // RL9
      end else begin
        // peripheral owns direction, gpio direction ignored
        pin_o <= func_sel ? func_o : gpio_o; // RL18
        pin_oe <= func_sel ? func_oe : gpio_oe; // RL18
        pin_keep <= 1'b0;
        in_q <= pin_i; // RL8
      end
    end
  end

  chk_stop_keeper: assert property (@(posedge pclk) // RL9
    disable iff (!presetn)
    clk_en && stop_mode && pin_oe |=> !pin_oe && pin_keep && $stable(pin_o))
    else $error("driven pin not kept on stop");

  chk_stop_ignore: assert property (@(posedge pclk) // RL8
    disable iff (!presetn)
    clk_en && stop_mode |=> $stable(in_q))
    else $error("input sampled during stop");

endmodule : pin_cell

// ==== core/timer_unit.sv ====
// timer_unit: one event/clock counter with compare and pin output.
// assumes pin_in already sampled on pclk.
`timescale 1ns/100ps
module timer_unit #(
  parameter int TW = 24
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire pin_mux_pkg::tmr_mode_t mode,
  input wire logic enable,
  input wire logic [TW-1:0] limit,
  input wire logic pin_in,
  output logic [TW-1:0] count_q,
  output logic tick_q,
  output logic tout_q
);

  logic pin_q;
  logic rise;
  logic fall;
  logic inc;
  logic hit;

  assign rise = pin_in && !pin_q;
  assign fall = !pin_in && pin_q;

  // ----------------------------------------------------------------
  // event source and terminal count
  // ----------------------------------------------------------------
  always_comb begin
    case (mode)
      pin_mux_pkg::TM_GPIO: inc = 1'b0;
      pin_mux_pkg::TM_EVENT: inc = enable && rise; // RL12
      pin_mux_pkg::TM_MEASURE: inc = enable && pin_in;
      default: inc = enable; // RL12
    endcase
  end
  assign hit = (mode == pin_mux_pkg::TM_MEASURE) ? (enable && fall)
             : (inc && count_q == limit); // RL13

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_q <= 1'b0;
      count_q <= '0;
      tick_q <= 1'b0;
    end else if (clk_en) begin
      pin_q <= pin_in;
      tick_q <= hit;
      if (!enable) count_q <= '0;
      else if (mode == pin_mux_pkg::TM_MEASURE && rise) count_q <= '0;
      else if (hit && mode != pin_mux_pkg::TM_MEASURE) count_q <= '0;
      else if (inc) count_q <= count_q + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // pin output per mode
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tout_q <= 1'b0;
    end else if (clk_en) begin
      case (mode)
        pin_mux_pkg::TM_TIMER: if (hit) tout_q <= !tout_q; // RL13
        pin_mux_pkg::TM_WATCHDOG: if (hit) tout_q <= 1'b1;
        pin_mux_pkg::TM_PWM: tout_q <= enable && (count_q < (limit >> 1));
        default: tout_q <= 1'b0;
      endcase
    end
  end

  chk_event_count: assert property (@(posedge pclk) // RL12
    disable iff (!presetn)
    clk_en && enable && mode == pin_mux_pkg::TM_EVENT && rise
    && count_q != limit |=> count_q == $past(count_q) + 1'b1)
    else $error("external event not counted");

endmodule : timer_unit

// ==== bench/ext_peer_model.sv ====
// ext_peer_model: serial peers and timer event sources on the far side
// of the pins; resolves each pin level from all drivers.
// assumes the bench commands the peer levels synchronously to pclk.
`timescale 1ns/100ps
module ext_peer_model (
  input wire pin_mux_pkg::pin_grp_t port_e_pins,
  input wire pin_mux_pkg::pin_grp_t timer_pins,
  input wire logic [2:0] pe_ext,
  input wire logic [2:0] tm_ext,
  output logic [2:0] pe_level,
  output logic [2:0] tm_level
);
  // ----------------------------------------------------------------
  // pin resolution
  // ----------------------------------------------------------------
  // the device driver wins, then its keeper, else the peer drives
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      if (port_e_pins.oe[i] || port_e_pins.keep[i]) begin
        pe_level[i] = port_e_pins.o[i];
      end else begin
        pe_level[i] = pe_ext[i];
      end
    end
  end

  always_comb begin
    for (int i = 0; i < 3; i++) begin
      if (timer_pins.oe[i] || timer_pins.keep[i]) begin
        tm_level[i] = timer_pins.o[i];
      end else begin
        tm_level[i] = tm_ext[i];
      end
    end
  end
endmodule : ext_peer_model

// ==== bench/testbench.sv ====
// testbench: self-checking bench for the serial and timer pin mux.
// assumes the pin mux package and the far-side peer model are compiled.
`timescale 1ns/100ps
module testbench;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic clk_en = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic stop_mode = 1'b0;
  logic [2:0] port_e_pin_i;
  logic [2:0] timer_pin_i;
  pin_mux_pkg::pin_grp_t port_e_pins;
  pin_mux_pkg::pin_grp_t timer_pins;
  pin_mux_pkg::ser_drv_t ser_drv = '0;
  pin_mux_pkg::ser_in_t ser_in;
  logic irq;
  logic [2:0] pe_ext = 3'h0;
  logic [2:0] tm_ext = 3'h0;
  logic [31:0] rd;
  logic err;
  int n_mismatch = 0;
  int checks = 0;

  always #10 pclk = ~pclk;

  serial_timer_pin_mux serial_timer_pin_mux_inst (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .stop_mode(stop_mode), .port_e_pin_i(port_e_pin_i),
    .port_e_pins(port_e_pins), .timer_pin_i(timer_pin_i),
    .timer_pins(timer_pins), .ser_drv(ser_drv), .ser_in(ser_in), .irq(irq)
  );

  ext_peer_model ext_peer_model_inst (
    .port_e_pins(port_e_pins), .timer_pins(timer_pins), .pe_ext(pe_ext),
    .tm_ext(tm_ext), .pe_level(port_e_pin_i), .tm_level(timer_pin_i)
  );

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                       input string what);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("FAIL t=%0t %s seen %h exp %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic settle(input int n);
    repeat (n) @(posedge pclk);
    @(negedge pclk);
  endtask : settle

  task automatic final_report;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : final_report

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    check({29'h0, port_e_pins.oe}, 32'h0, "pe oe");
    check({29'h0, timer_pins.oe}, 32'h0, "tm oe");
    check({31'h0, ser_in.rxd}, 32'h1, "rxd idle");
    check({31'h0, irq}, 32'h0, "irq");
    apb(1'b0, pin_mux_pkg::PE_CTRL_OFF, 32'h0);
    check(rd, 32'h0, "pe ctrl");
    apb(1'b0, pin_mux_pkg::TCS_BASE_OFF, 32'h0);
    check(rd, 32'h0, "tcs0");
    apb(1'b0, pin_mux_pkg::TLIM_BASE_OFF, 32'h0);
    check(rd, 32'h0000_FFFF, "tlim0");
    apb(1'b0, 8'hFC, 32'h0);
    check({rd[30:0], err}, 32'h1, "unmapped");
    $display("test reset done");
  endtask : t_reset

  task automatic t_gpio;
    pe_ext <= 3'h2;
    apb(1'b1, pin_mux_pkg::PE_DIR_OFF, 32'h5);
    apb(1'b1, pin_mux_pkg::PE_DATA_OFF, 32'h4);
    settle(3);
    check({26'h0, port_e_pins.oe, port_e_pins.o}, 32'h2C, "gpio");
    apb(1'b0, pin_mux_pkg::PE_DATA_OFF, 32'h0);
    check(rd, 32'h6, "pe levels");
    $display("test gpio done");
  endtask : t_gpio

  task automatic t_serial;
    ser_drv <= '{txd: 1'b1, sclk_o: 1'b0, sclk_oe: 1'b1};
    pe_ext <= 3'h1;
    apb(1'b1, pin_mux_pkg::PE_DIR_OFF, 32'h1);
    apb(1'b1, pin_mux_pkg::PE_CTRL_OFF, 32'h7);
    settle(3);
    check({29'h0, port_e_pins.oe}, 32'h6, "ser oe");
    check({31'h0, port_e_pins.o[1]}, 32'h1, "txd hi");
    check({31'h0, ser_in.rxd}, 32'h1, "rxd hi");
    @(posedge pclk);
    ser_drv.txd <= 1'b0;
    pe_ext[0] <= 1'b0;
    settle(3);
    check({30'h0, port_e_pins.o[1], ser_in.rxd}, 32'h0, "duplex");
    @(posedge pclk);
    ser_drv.sclk_oe <= 1'b0;
    pe_ext[2] <= 1'b1;
    settle(3);
    check({30'h0, port_e_pins.oe[2], ser_in.sclk_i}, 32'h1, "sclk");
    $display("test serial done");
  endtask : t_serial

  task automatic t_stop;
    @(posedge pclk);
    ser_drv.txd <= 1'b1;
    settle(3);
    @(posedge pclk);
    stop_mode <= 1'b1;
    pe_ext[0] <= 1'b1;
    settle(3);
    check({29'h0, port_e_pins.oe}, 32'h0, "stop oe");
    check({29'h0, port_e_pins.keep}, 32'h2, "stop keep");
    check({29'h0, timer_pins.keep}, 32'h0, "tm keep");
    check({31'h0, port_e_pins.o[1]}, 32'h1, "stop hold");
    check({31'h0, ser_in.rxd}, 32'h0, "stop in");
    @(posedge pclk);
    stop_mode <= 1'b0;
    settle(3);
    check({29'h0, port_e_pins.oe}, 32'h2, "wake oe");
    check({31'h0, ser_in.rxd}, 32'h1, "wake in");
    $display("test stop done");
  endtask : t_stop

  task automatic t_timer_out;
    int i;
    apb(1'b1, pin_mux_pkg::TLIM_BASE_OFF, 32'h3);
    apb(1'b1, pin_mux_pkg::IRQ_MASK_OFF, 32'h1);
    apb(1'b1, pin_mux_pkg::TCS_BASE_OFF, 32'h24);
    for (i = 0; i < 40 && irq !== 1'b1; i++) settle(0);
    check({31'h0, irq}, 32'h1, "irq set");
    check({31'h0, timer_pins.oe[0]}, 32'h1, "t0 out");
    apb(1'b1, pin_mux_pkg::TCS_BASE_OFF, 32'h0);
    apb(1'b0, pin_mux_pkg::IRQ_STAT_OFF, 32'h0);
    check(rd, 32'h1, "stat");
    apb(1'b1, pin_mux_pkg::IRQ_STAT_OFF, 32'h1);
    settle(2);
    check({31'h0, irq}, 32'h0, "irq clr");
    apb(1'b0, pin_mux_pkg::TCNT_BASE_OFF + 8'h08, 32'h0);
    check(rd, 32'h0, "t2 idle");
    $display("test timer out done");
  endtask : t_timer_out

  task automatic t_event;
    apb(1'b1, pin_mux_pkg::TCS_BASE_OFF + 8'h04, 32'h21);
    settle(2);
    check({31'h0, timer_pins.oe[1]}, 32'h0, "t1 in");
    repeat (5) begin
      @(posedge pclk);
      tm_ext[1] <= 1'b1;
      repeat (2) @(posedge pclk);
      tm_ext[1] <= 1'b0;
      repeat (2) @(posedge pclk);
    end
    settle(2);
    apb(1'b0, pin_mux_pkg::TCNT_BASE_OFF + 8'h04, 32'h0);
    check(rd, 32'h5, "events");
    $display("test event done");
  endtask : t_event

  task automatic t_modes;
    logic exp_oe;
    for (int m = 0; m < 6; m++) begin
      exp_oe = !(m == 1 || m == 2);
      apb(1'b1, pin_mux_pkg::TCS_BASE_OFF + 8'h08, 32'h18 | 32'(m));
      settle(2);
      check({31'h0, timer_pins.oe[2]}, {31'h0, exp_oe}, "mode oe");
      check({31'h0, timer_pins.o[2]}, {31'h0, m == 0}, "mode o");
    end
    $display("test modes done");
  endtask : t_modes

  task automatic t_freeze;
    @(posedge pclk);
    clk_en <= 1'b0;
    fork
      apb(1'b0, pin_mux_pkg::TLIM_BASE_OFF, 32'h0);
      begin
        settle(3);
        check({29'h0, pready, timer_pins.oe[2], irq}, 32'h2, "frozen");
        @(posedge pclk);
        clk_en <= 1'b1;
      end
    join
    check(rd, 32'h3, "late read");
    $display("test freeze done");
  endtask : t_freeze

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    settle(1);
    t_reset();
    t_gpio();
    t_serial();
    t_stop();
    t_timer_out();
    t_event();
    t_modes();
    t_freeze();
    final_report();
  end

  initial begin
    #400000;
    n_mismatch++;
    final_report();
  end
endmodule : testbench
